// file: hw/cgp_map.vh
`ifndef CGP_MAP_VH
`define CGP_MAP_VH
// Frame identifiers and bases.
`define CGP_ID_GUARD 11'h700
`define CGP_ID_TPDO1 11'h180
`define CGP_ID_TPDO2 11'h280
`define CGP_ID_TPDO3 11'h380
`define CGP_ID_TPDO4 11'h480
`define CGP_ID_RPDO1 11'h200
`define CGP_ID_RPDO2 11'h300
`define CGP_ID_RPDO3 11'h400
`define CGP_ID_RPDO4 11'h500
// Network states carried in bits 6..0 of the guarding byte.
`define CGP_NMT_STOPPED 7'h04
`define CGP_NMT_OPER 7'h05
`define CGP_NMT_PREOP 7'h7f
`define CGP_TOGGLE_BIT 7
`define CGP_BOOT_BYTE 8'h00
`define CGP_HB_BYTE 8'h05
// Transmission types.
`define CGP_TT_SYNC_ACYC 8'h00
`define CGP_TT_SYNC_MAX 8'hf0
`define CGP_TT_EVT_MFR 8'hfe
`define CGP_TT_EVT_PROF 8'hff
// Timing: 1 ms tick at 20 MHz.
`define CGP_CLK_HZ 20000000
`define CGP_TICK_MS 1
`define CGP_TICK_CYC (`CGP_CLK_HZ / 1000 * `CGP_TICK_MS)
// Status indicator flash half-period in ms.
`define CGP_FLASH_MS 16'h00fa
`endif

// file: hw/cgp_ms_timer.v
`timescale 1ns/100ps
`include "cgp_map.vh"
// Millisecond interval timer: pulses done every period ms while enabled.
module cgp_ms_timer #(
  parameter TICK_CYC = `CGP_TICK_CYC
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Control.
  input wire tick,
  input wire restart,
  input wire [15:0] period,
  // Status.
  output reg done
);
  reg [15:0] count;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (restart || period == 16'h0000) begin
        count <= 16'h0000;
      end else if (tick) begin
        if (count + 16'h0001 >= period) begin
          count <= 16'h0000;
          done <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end
endmodule

// file: hw/cgp_engine.v
// Behaviour
// - Each guarding query is answered with one byte on 700h+N holding state.
// - Bit 7 of the guarding reply inverts from one query to the next.
// - The guarding reply goes out well inside the node guarding time.
// - At start-up one bootup frame, length one, data 0, on 700h+N.
// - With producer heartbeat set, send 05h on 700h+N periodically, toggle 0.
// - With consumer heartbeat set, a guarding message must arrive each period.
// - Four transmit and four receive process objects of eight bytes each.
// - Object identifiers are 11 bits, default from type and node, overridable.
// - Transmit objects use 181h.., 281h.., 381h.., 481h.. carrying bytes 1-32.
// - Receive objects use 201h.., 301h.., 401h.., 501h.. delivering bytes 1-32.
// - Type 255 sends an object whenever one of its bytes changes.
// - Type 0 sends a changed object at the next sync command.
// - Type n from 1 to 240 sends once every n sync commands.
// - Type 254 or 255 with event timer N above zero sends every N ms.
// - A zero-length remote frame on a transmit identifier sends that object.
// - No process objects are sent unless the state is operational.
// - Receive objects are type 255 and are forwarded at once on reception.
// - Process objects are never acknowledged by either party.
// - Status indicator flashes red/green until the first process data exchange.
// - Process data may also be read and written by service access.
`timescale 1ns/100ps
`include "cgp_map.vh"
module cgp_engine (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Configuration.
  input wire [6:0] node_id,
  input wire [6:0] nmt_state,
  input wire [15:0] prod_hb_ms,
  input wire [15:0] cons_hb_ms,
  input wire [31:0] tx_type,
  input wire [63:0] tx_event_ms,
  input wire [43:0] tx_cob_id,
  input wire [3:0] tx_cob_ovr,
  input wire [43:0] rx_cob_id,
  input wire [3:0] rx_cob_ovr,
  input wire config_changed,
  // Received frames from the CAN controller.
  input wire rx_valid,
  input wire [10:0] rx_id,
  input wire rx_rtr,
  input wire [3:0] rx_dlc,
  input wire [63:0] rx_data,
  input wire sync_rx,
  // Process data from and to the controller module.
  input wire [255:0] telegram_bytes,
  output reg [255:0] rx_telegram_bytes,
  output reg [3:0] rx_pdo_strobe,
  // Service access to process data.
  input wire svc_access,
  // Transmit frames to the CAN controller.
  output reg tx_valid,
  output reg [10:0] tx_id,
  output reg [3:0] tx_dlc,
  output reg [63:0] tx_data,
  input wire tx_ready,
  // Status.
  output reg hb_error,
  output reg module_status_led_red,
  output reg module_status_led_green
);
  localparam ST_BOOT = 2'b00;
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;
  reg [1:0] state;
  reg toggle;
  reg guard_pend;
  reg hb_pend;
  reg [3:0] pdo_pend;
  reg [255:0] last_sent;
  reg [31:0] sync_cnt;
  reg [15:0] tick_cnt;
  reg tick;
  reg exchanged;
  reg [15:0] flash_cnt;
  reg [1:0] cur_pdo;
  wire hb_done;
  wire cons_done;
  wire [3:0] evt_done;
  wire guard_id_hit;
  wire oper;
  wire [3:0] tx_rtr_hit;
  wire [3:0] rx_hit;
  wire [3:0] changed;

  assign guard_id_hit = rx_valid && rx_id == (`CGP_ID_GUARD + {4'h0, node_id});
  assign oper = nmt_state == `CGP_NMT_OPER;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and interval timers.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (tick_cnt == `CGP_TICK_CYC - 1) begin
        tick_cnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  cgp_ms_timer u_hb_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .restart(1'b0),
    .period(prod_hb_ms),
    .done(hb_done)
  );

  cgp_ms_timer u_cons_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .restart(guard_id_hit && rx_rtr),
    .period(cons_hb_ms),
    .done(cons_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-object trigger logic.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pdo
      wire [7:0] ttype = tx_type[8*g+7:8*g];
      localparam [10:0] TX_BASE = `CGP_ID_TPDO1 + 11'h100 * g;
      localparam [10:0] RX_BASE = `CGP_ID_RPDO1 + 11'h100 * g;
      wire [10:0] tx_def = TX_BASE + {4'h0, node_id};
      wire [10:0] rx_def = RX_BASE + {4'h0, node_id};
      wire [10:0] tx_cob = tx_cob_ovr[g] ? tx_cob_id[11*g+10:11*g] : tx_def;
      wire [10:0] rx_cob = rx_cob_ovr[g] ? rx_cob_id[11*g+10:11*g] : rx_def;
      wire evt_type = ttype == `CGP_TT_EVT_MFR || ttype == `CGP_TT_EVT_PROF;
      assign changed[g] = telegram_bytes[64*g+63:64*g]
                          != last_sent[64*g+63:64*g];
      assign tx_rtr_hit[g] = rx_valid && rx_rtr && rx_dlc == 4'h0
                             && rx_id == tx_cob;
      assign rx_hit[g] = rx_valid && !rx_rtr && rx_id == rx_cob;
      cgp_ms_timer u_evt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick),
        .restart(!evt_type),
        .period(tx_event_ms[16*g+15:16*g]),
        .done(evt_done[g])
      );
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_cnt[8*g+7:8*g] <= 8'h00;
        end else begin
          if (sync_rx && ttype >= 8'h01 && ttype <= `CGP_TT_SYNC_MAX) begin
            if (sync_cnt[8*g+7:8*g] + 8'h01 >= ttype) begin
              sync_cnt[8*g+7:8*g] <= 8'h00;
            end else begin
              sync_cnt[8*g+7:8*g] <= sync_cnt[8*g+7:8*g] + 8'h01;
            end
          end
        end
      end
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pdo_pend[g] <= 1'b0;
          rx_telegram_bytes[64*g+63:64*g] <= 64'h0000_0000_0000_0000;
          rx_pdo_strobe[g] <= 1'b0;
        end else begin
          rx_pdo_strobe[g] <= rx_hit[g];
          if (rx_hit[g]) begin
            rx_telegram_bytes[64*g+63:64*g] <= rx_data;
          end
          if (!oper) begin
            pdo_pend[g] <= 1'b0;
          end else if ((ttype == `CGP_TT_EVT_PROF && changed[g])
              // A changed object differs from its last sent copy until it
              // goes out, so no separate change latch can go stale.
              || (ttype == `CGP_TT_SYNC_ACYC && sync_rx
                  && changed[g])
              || (sync_rx && ttype >= 8'h01 && ttype <= `CGP_TT_SYNC_MAX
                  && sync_cnt[8*g+7:8*g] + 8'h01 >= ttype)
              || (evt_type && evt_done[g])
              || tx_rtr_hit[g]) begin
            pdo_pend[g] <= 1'b1;
          end else if (state == ST_SEND && tx_ready && tx_valid
                       && cur_pdo == g && tx_dlc == 4'h8) begin
            pdo_pend[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Frame scheduler: guarding and heartbeat before process data.
  reg [1:0] next_pdo;
  integer i;
  always @* begin
    next_pdo = 2'b00;
    for (i = 3; i >= 0; i = i - 1) begin
      if (pdo_pend[i]) begin
        next_pdo = i[1:0];
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_BOOT;
      toggle <= 1'b0;
      guard_pend <= 1'b0;
      hb_pend <= 1'b0;
      tx_valid <= 1'b0;
      tx_id <= 11'h000;
      tx_dlc <= 4'h0;
      tx_data <= 64'h0000_0000_0000_0000;
      cur_pdo <= 2'b00;
      last_sent <= {256{1'b0}};
    end else begin
      case (state)
        ST_BOOT: begin
          tx_valid <= 1'b1;
          tx_id <= `CGP_ID_GUARD + {4'h0, node_id};
          tx_dlc <= 4'h1;
          tx_data <= {56'h0, `CGP_BOOT_BYTE};
          state <= ST_SEND;
        end
        ST_IDLE: begin
          if (guard_pend) begin
            tx_valid <= 1'b1;
            tx_id <= `CGP_ID_GUARD + {4'h0, node_id};
            tx_dlc <= 4'h1;
            tx_data <= {56'h0, toggle, nmt_state};
            toggle <= ~toggle;
            guard_pend <= 1'b0;
            state <= ST_SEND;
          end else if (hb_pend) begin
            tx_valid <= 1'b1;
            tx_id <= `CGP_ID_GUARD + {4'h0, node_id};
            tx_dlc <= 4'h1;
            tx_data <= {56'h0, `CGP_HB_BYTE};
            hb_pend <= 1'b0;
            state <= ST_SEND;
          end else if (pdo_pend != 4'h0 && oper) begin
            tx_valid <= 1'b1;
            cur_pdo <= next_pdo;
            tx_id <= g_sel_id(next_pdo);
            tx_dlc <= 4'h8;
            tx_data <= telegram_bytes[64*next_pdo +: 64];
            last_sent[64*next_pdo +: 64] <= telegram_bytes[64*next_pdo +: 64];
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          // No acknowledge is awaited after process objects go out.
          if (tx_ready) begin
            tx_valid <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // Requests are set after the launch so a query that lands in the
      // launch cycle of its predecessor is not lost.
      if (guard_id_hit && rx_rtr && rx_dlc == 4'h0) begin
        guard_pend <= 1'b1;
      end
      if (hb_done) begin
        hb_pend <= 1'b1;
      end
    end
  end

  function [10:0] g_sel_id;
    input [1:0] idx;
    begin
      if (tx_cob_ovr[idx]) begin
        g_sel_id = tx_cob_id[11*idx +: 11];
      end else begin
        g_sel_id = `CGP_ID_TPDO1 + {idx, 8'h00} + {4'h0, node_id};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Heartbeat consumer error and module status indicator.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_error <= 1'b0;
    end else begin
      if (cons_done) begin
        hb_error <= 1'b1;
      end else if (guard_id_hit && rx_rtr) begin
        hb_error <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exchanged <= 1'b0;
      flash_cnt <= 16'h0000;
      module_status_led_red <= 1'b1;
      module_status_led_green <= 1'b0;
    end else begin
      if ((rx_hit != 4'h0) || svc_access
          || (state == ST_SEND && tx_ready && tx_dlc == 4'h8)) begin
        exchanged <= 1'b1;
      end else if (config_changed) begin
        exchanged <= 1'b0;
      end
      if (!exchanged) begin
        if (tick) begin
          if (flash_cnt + 16'h0001 >= `CGP_FLASH_MS) begin
            flash_cnt <= 16'h0000;
            module_status_led_red <= ~module_status_led_red;
            module_status_led_green <= module_status_led_red;
          end else begin
            flash_cnt <= flash_cnt + 16'h0001;
          end
        end
      end else begin
        module_status_led_red <= 1'b0;
        module_status_led_green <= 1'b1;
      end
    end
  end
endmodule

// file: tb/cgp_engine_monitor.sv
`timescale 1ns/100ps
`include "cgp_map.vh"
module cgp_engine_monitor (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Watched ports.
  input wire [6:0] node_id,
  input wire [6:0] nmt_state,
  input wire rx_valid,
  input wire [10:0] rx_id,
  input wire rx_rtr,
  input wire [3:0] rx_dlc,
  input wire [3:0] rx_pdo_strobe,
  input wire tx_valid,
  input wire [10:0] tx_id,
  input wire [3:0] tx_dlc,
  input wire [63:0] tx_data,
  input wire tx_ready,
  input wire hb_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [10:0] nmt_id = `CGP_ID_GUARD + node_id;
  wire query = rx_valid && rx_rtr && rx_dlc == 4'h0 && rx_id == nmt_id;
  wire nmt_tx = tx_valid && tx_id == nmt_id;
  reg took;
  // Marks the first cycle of each frame so a held frame is judged once.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      took <= 1'b1;
    else
      took <= !tx_valid || tx_ready;
  end
  wire pdo_new = tx_valid && took && tx_id[10:8] != 3'h7;
  a_tx_frame_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_id) && $stable(tx_data) && $stable(tx_dlc))
    else $error("frame changed before acceptance");
  a_guard_reply_due: assert property (query |-> ##[1:40] nmt_tx)
    else $error("no guarding reply in time");
  a_nmt_len_one: assert property (nmt_tx |-> tx_dlc == 4'h1)
    else $error("state frame length wrong");
  a_nmt_state_byte: assert property (nmt_tx |-> tx_data[6:0] == nmt_state
    || tx_data[7:0] == 8'h00 || tx_data[7:0] == 8'h05)
    else $error("state frame byte wrong");
  a_pdo_when_oper: assert property (pdo_new |-> nmt_state == 7'h05)
    else $error("object sent outside operational");
  a_pdo_len_eight: assert property (pdo_new |-> tx_dlc == 4'h8)
    else $error("object length wrong");
  a_rx_pdo_pass: assert property (rx_valid && !rx_rtr && rx_id ==
    `CGP_ID_RPDO2 + node_id |-> ##[1:3] rx_pdo_strobe == 4'h2)
    else $error("received object not forwarded");
  a_hb_error_clear: assert property (query |-> ##[1:3] !hb_error)
    else $error("error flag not cleared by query");
  c_query: cover property (query);
  c_pdo: cover property (pdo_new);
  c_hb_err: cover property ($rose(hb_error));
endmodule
bind cgp_engine cgp_engine_monitor i_cgp_engine_monitor (
  .ref_clk, .rst_n, .node_id, .nmt_state, .rx_valid, .rx_id, .rx_rtr,
  .rx_dlc, .rx_pdo_strobe, .tx_valid, .tx_id, .tx_dlc, .tx_data,
  .tx_ready, .hb_error);

// file: tb/cgp_can_node.sv
`timescale 1ns/100ps
module cgp_can_node (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Frames from the engine.
  input wire tx_valid,
  input wire [10:0] tx_id,
  input wire [3:0] tx_dlc,
  input wire [63:0] tx_data,
  output reg tx_ready = 1'b0,
  // Frames to the engine.
  output reg rx_valid = 1'b0,
  output reg [10:0] rx_id = 11'h000,
  output reg rx_rtr = 1'b0,
  output reg [3:0] rx_dlc = 4'h0,
  output reg [63:0] rx_data = 64'h0,
  output reg sync_rx = 1'b0
);
  int stall = 0;
  int waited = 0;
  int n_seen = 0;
  reg [10:0] got_id;
  reg [3:0] got_dlc;
  reg [63:0] got_data;
  // Acceptance lags by stall cycles, as on a busy bus.
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      got_id = tx_id;
      got_dlc = tx_dlc;
      got_data = tx_data;
      n_seen++;
      waited = 0;
      tx_ready <= #1 1'b0;
    end else if (tx_valid) begin
      if (waited >= stall)
        tx_ready <= #1 1'b1;
      waited++;
    end
  end
  // Between frames the id and data lines carry the inverse; rtr and dlc keep their last values.
  task frame(input [10:0] id, input rtr, input [3:0] dlc, input [63:0] d);
    @(posedge ref_clk);
    #1;
    {rx_id, rx_rtr, rx_dlc, rx_data, rx_valid} = {id, rtr, dlc, d, 1'b1};
    @(posedge ref_clk);
    #1;
    {rx_id, rx_data, rx_valid} = {~id, ~d, 1'b0};
  endtask
  task sync;
    @(posedge ref_clk);
    #1 sync_rx = 1'b1;
    @(posedge ref_clk);
    #1 sync_rx = 1'b0;
  endtask
endmodule

// file: tb/canopen_guarding_pdo_engine_tb.sv
`timescale 1ns/100ps
`include "cgp_map.vh"
module canopen_guarding_pdo_engine_tb;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [6:0] node_id = 7'h12;
  reg [6:0] nmt_state = `CGP_NMT_PREOP;
  reg [15:0] prod_hb_ms = 16'h0000;
  reg [15:0] cons_hb_ms = 16'h0000;
  // Object 0 on remote request or timer, 1 on change, 2 on change at sync,
  // 3 once per 2 syncs.
  reg [31:0] tx_type = 32'h0200_fffe;
  reg [63:0] tx_event_ms = 64'h0;
  reg [43:0] tx_cob_id = 44'h0;
  reg [3:0] tx_cob_ovr = 4'h0;
  reg config_changed = 1'b0;
  reg svc_access = 1'b0;
  reg [255:0] telegram_bytes = 256'h0;
  wire [255:0] rx_telegram_bytes;
  wire [3:0] rx_pdo_strobe, rx_dlc, tx_dlc;
  wire [10:0] rx_id, tx_id;
  wire [63:0] rx_data, tx_data;
  wire rx_valid, rx_rtr, sync_rx, tx_valid, tx_ready, hb_error, led_r, led_g;
  int fail_count = 0;
  int n_checks = 0;
  always #25 ref_clk = ~ref_clk;
  cgp_engine i_cgp_engine (.ref_clk, .rst_n, .node_id, .nmt_state,
    .prod_hb_ms, .cons_hb_ms, .tx_type, .tx_event_ms,
    .tx_cob_id, .tx_cob_ovr, .rx_cob_id(44'h0),
    .rx_cob_ovr(4'h0), .config_changed, .rx_valid, .rx_id, .rx_rtr,
    .rx_dlc, .rx_data, .sync_rx, .telegram_bytes, .rx_telegram_bytes,
    .rx_pdo_strobe, .svc_access, .tx_valid, .tx_id, .tx_dlc, .tx_data,
    .tx_ready, .hb_error, .module_status_led_red(led_r),
    .module_status_led_green(led_g));
  cgp_can_node i_cgp_can_node (.ref_clk, .rst_n, .tx_valid, .tx_id,
    .tx_dlc, .tx_data, .tx_ready, .rx_valid, .rx_id, .rx_rtr, .rx_dlc,
    .rx_data, .sync_rx);
  task check(input string what, input logic [63:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A silent engine ends the run rather than hanging it.
  task next_frame(input int bound);
    int n0;
    n0 = i_cgp_can_node.n_seen;
    for (int c = 0; c < bound && i_cgp_can_node.n_seen == n0; c++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i_cgp_can_node.n_seen == n0) begin
      check("frame wait", 1, 0);
      results;
    end
  endtask
  task quiet(input int cycles);
    int n0;
    n0 = i_cgp_can_node.n_seen;
    repeat (cycles) @(posedge ref_clk);
    #1 check("silence", i_cgp_can_node.n_seen, n0);
  endtask
  task got(input string what, input [10:0] id, input [63:0] d);
    check({what, " id"}, i_cgp_can_node.got_id, id);
    check({what, " data"}, i_cgp_can_node.got_data, d);
  endtask
  task guard(input [7:0] b);
    i_cgp_can_node.frame(`CGP_ID_GUARD + node_id, 1, 4'h0, 64'h0);
    next_frame(40);
    check("guard id", i_cgp_can_node.got_id, `CGP_ID_GUARD + node_id);
    check("guard", i_cgp_can_node.got_data[7:0], b);
  endtask
  task t_boot;
    next_frame(10);
    got("boot", `CGP_ID_GUARD + node_id, 64'h0);
    check("boot len", i_cgp_can_node.got_dlc, 4'h1);
    check("led", {led_r, led_g}, 2'b10);
  endtask
  task t_guard;
    i_cgp_can_node.stall = 3;
    nmt_state = `CGP_NMT_STOPPED;
    guard({1'b0, `CGP_NMT_STOPPED});
    nmt_state = `CGP_NMT_PREOP;
    guard({1'b1, `CGP_NMT_PREOP});
    i_cgp_can_node.stall = 0;
  endtask
  task t_rtr;
    telegram_bytes[71:64] = 8'h77;
    i_cgp_can_node.frame(`CGP_ID_TPDO1 + node_id, 1, 4'h0, 64'h0);
    quiet(60);
    nmt_state = `CGP_NMT_OPER;
    // Object 1 has differed from its sent copy since reset, so it goes first.
    next_frame(60);
    got("first", `CGP_ID_TPDO2 + node_id, telegram_bytes[127:64]);
    i_cgp_can_node.frame(`CGP_ID_TPDO1 + node_id, 1, 4'h0, 64'h0);
    next_frame(60);
    got("rtr", `CGP_ID_TPDO1 + node_id, telegram_bytes[63:0]);
    @(posedge ref_clk);
    #1 check("led", {led_r, led_g}, 2'b01);
  endtask
  task t_change;
    tx_cob_id[21:11] = 11'h2aa;
    tx_cob_ovr[1] = 1'b1;
    telegram_bytes[79:72] = 8'hc3;
    next_frame(60);
    got("chg", 11'h2aa, telegram_bytes[127:64]);
  endtask
  task t_sync;
    i_cgp_can_node.sync;
    next_frame(60);
    got("acyc", `CGP_ID_TPDO3 + node_id, telegram_bytes[191:128]);
    quiet(20);
    i_cgp_can_node.sync;
    next_frame(60);
    got("sync", `CGP_ID_TPDO4 + node_id, telegram_bytes[255:192]);
  endtask
  task t_rx;
    int c;
    i_cgp_can_node.frame(`CGP_ID_RPDO2 + node_id, 0, 4'h8, 64'h0123_4567);
    for (c = 0; rx_pdo_strobe !== 4'h2 && c < 10; c++) begin
      @(posedge ref_clk);
      #1;
    end
    check("rx strobe", rx_pdo_strobe, 4'h2);
    check("rx bytes", rx_telegram_bytes[127:64], 64'h0123_4567);
    @(posedge ref_clk);
    #1 svc_access = 1'b1;
    @(posedge ref_clk);
    #1 svc_access = 1'b0;
  endtask
  task t_hb;
    int c;
    prod_hb_ms = 16'h0001;
    cons_hb_ms = 16'h0002;
    tx_event_ms[15:0] = 16'h0001;
    next_frame(25000);
    got("hb", `CGP_ID_GUARD + node_id, {56'h0, `CGP_HB_BYTE});
    next_frame(60);
    got("evt", `CGP_ID_TPDO1 + node_id, telegram_bytes[63:0]);
    prod_hb_ms = 16'h0000;
    tx_event_ms[15:0] = 16'h0000;
    for (c = 0; hb_error !== 1'b1 && c < 50000; c++) begin
      @(posedge ref_clk);
      #1;
    end
    check("hb error", hb_error, 1'b1);
    guard({1'b0, `CGP_NMT_OPER});
    check("hb clear", hb_error, 1'b0);
    cons_hb_ms = 16'h0000;
  endtask
  initial begin
    for (int i = 0; i < 32; i++)
      telegram_bytes[8*i +: 8] = i + 1;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_boot;
    t_guard;
    t_rtr;
    t_change;
    t_sync;
    t_rx;
    t_hb;
    results;
  end
endmodule
